/* File: src/jbs_cfg.svh */
// constants for the jtag boundary scan and flash access block
`ifndef JBS_CFG_SVH
`define JBS_CFG_SVH
`define JBS_IR_W 16
`define JBS_IR_EXTEST 16'h0000
`define JBS_IR_SAMPLE 16'h0002
`define JBS_IR_IDCODE 16'h0004
`define JBS_IR_BYPASS 16'hFFFF
`define JBS_IR_FCTRL 16'h0082
`define JBS_IR_FDATA 16'h0083
`define JBS_IR_FADDR 16'h0084
`define JBS_IR_FSCALE 16'h0085
`define JBS_IR_RST `JBS_IR_IDCODE
`define JBS_IR_CAPTURE 16'h0001
`define JBS_BSR_LEN 87
`define JBS_ID_LEN 32
`define JBS_IND_LEN 20
`define JBS_IND_OP_BIT 19
`define JBS_IND_RW_BIT 18
`define JBS_PAY_W 18
`define JBS_CELL_XTAL 2
`define JBS_PIN_IN_BASE 24
`define JBS_PIN_CNT 32
`define JBS_FADDR_W 16
`define JBS_WR_PROG 4'h1
`define JBS_WR_ERASE 4'h2
`define JBS_RD_BLOCK 4'h1
`define JBS_RD_SINGLE 4'h2
`define JBS_ERASE_KEY 8'hA5
`define JBS_TOP_USER_PAIR 15'h3EFF
`define JBS_SCALE_OFF 4'hF
`define JBS_SCALE_RD_MASK 8'hCF
`define JBS_CTRL_RST 8'h00
`define JBS_DATA_RST 8'h00
`define JBS_ADDR_RST 16'h0000
`define JBS_SCALE_RST 8'h00
`endif

/* File: src/jbs_pkg.sv */
// types shared by the tap side and the flash engine
package jbs_pkg;
`include "jbs_cfg.svh"
	typedef enum logic [3:0] {
		TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
		TAP_SHIFT_DR = 4'h6, TAP_EXIT1_DR = 4'h7, TAP_PAUSE_DR = 4'h5, TAP_EXIT2_DR = 4'h4,
		TAP_UPD_DR = 4'hC, TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SHIFT_IR = 4'hE,
		TAP_EXIT1_IR = 4'hA, TAP_PAUSE_IR = 4'hB, TAP_EXIT2_IR = 4'h9, TAP_UPD_IR = 4'h8
	} jbs_tap_type;
	typedef enum logic [1:0] {IREG_CTRL = 2'h0, IREG_DATA = 2'h1, IREG_ADDR = 2'h2, IREG_SCALE = 2'h3} jbs_ireg_type;
	typedef enum logic [1:0] {FOP_READ = 2'h0, FOP_PROG = 2'h1, FOP_ERASE_PAGE = 2'h2, FOP_ERASE_ALL = 2'h3} jbs_fop_type;
	typedef enum logic {ENG_IDLE = 1'b0, ENG_WAIT = 1'b1} jbs_eng_st_type;
	typedef struct packed {
		logic rst_s1, rst_s2;
		jbs_tap_type tap;
		logic [`JBS_IR_W-1:0] ir, ir_sh;
		logic [`JBS_BSR_LEN-1:0] dr, cap_s1, cap_s2, upd;
		logic drive_en;
		logic [`JBS_PIN_CNT-1:0] core_in;
		logic req_tgl;
		jbs_ireg_type sel;
		logic wr;
		logic [`JBS_PAY_W-1:0] payload;
		logic ack_s1, ack_s2, busy_cap, tdo, tdo_en;
	} jbs_tck_type;
	typedef struct packed {
		logic req_s1, req_s2, req_s3, ack_tgl;
		logic [`JBS_PAY_W-1:0] result;
		logic [7:0] ctrl, data, scale;
		logic [`JBS_FADDR_W-1:0] addr;
		logic fail, unread, start;
		jbs_fop_type op;
		jbs_eng_st_type st;
	} jbs_eng_type;
endpackage

/* File: src/jbs_xfer_if.sv */
// command and answer crossing between scan clock and system clock
`timescale 1ns/1ps
`include "jbs_cfg.svh"
interface jbs_xfer_if import jbs_pkg::*; ();
	logic req_tgl;
	jbs_ireg_type sel;
	logic wr;
	logic [`JBS_PAY_W-1:0] payload;
	logic ack_tgl;
	logic [`JBS_PAY_W-1:0] result;
	modport port (output req_tgl, sel, wr, payload, input ack_tgl, result);
	modport engine (input req_tgl, sel, wr, payload, output ack_tgl, result);
endinterface

/* File: src/jbs_flash_engine.sv */
// system clock side: indirect flash registers and flash operation sequencing
`timescale 1ns/1ps
`include "jbs_cfg.svh"
module jbs_flash_engine import jbs_pkg::*; (
	// system
	input wire logic i_clk,
	input wire logic i_srst,
	// crossing
	jbs_xfer_if.engine x,
	// flash macro
	output logic o_flash_start,
	output jbs_fop_type o_flash_op,
	output logic [`JBS_FADDR_W-1:0] o_flash_addr,
	output logic [7:0] o_flash_wdata,
	output logic [7:0] o_flash_scale,
	input wire logic i_flash_done,
	input wire logic i_flash_fail,
	input wire logic [7:0] i_flash_rdata
);
	jbs_eng_type e, next_e;
	logic launch;
	jbs_fop_type lop;

	always_comb begin
		next_e = e;
		launch = 1'b0;
		lop = FOP_READ;
		next_e.req_s1 = x.req_tgl;
		next_e.req_s2 = e.req_s1;
		next_e.req_s3 = e.req_s2;
		next_e.start = 1'b0;
		case (e.st)
			ENG_IDLE: begin
				if (e.req_s2 != e.req_s3) begin
					if (x.wr) begin
						case (x.sel)
							IREG_CTRL: next_e.ctrl = x.payload[17:10];
							IREG_ADDR: next_e.addr = x.payload[17:2];
							IREG_SCALE: next_e.scale = x.payload[17:10] & `JBS_SCALE_RD_MASK;
							default: begin
								next_e.data = x.payload[17:10];
								// reserved write modes only store the byte
								if (e.ctrl[7:4] == `JBS_WR_PROG) begin
									launch = 1'b1;
									lop = FOP_PROG;
								end else if (e.ctrl[7:4] == `JBS_WR_ERASE && x.payload[17:10] == `JBS_ERASE_KEY) begin
									launch = 1'b1;
									lop = (e.addr[15:1] == `JBS_TOP_USER_PAIR) ? FOP_ERASE_ALL : FOP_ERASE_PAGE;
								end
							end
						endcase
					end else begin
						case (x.sel)
							IREG_CTRL: next_e.result = {10'h000, e.ctrl};
							IREG_ADDR: next_e.result = {2'h0, e.addr};
							IREG_SCALE: next_e.result = {10'h000, e.scale};
							default: begin
								// returns the held byte; a fetch refills it for the next read
								next_e.result = {8'h00, e.data, e.fail, 1'b0};
								next_e.unread = 1'b0;
								if (e.ctrl[3:0] == `JBS_RD_BLOCK || (e.ctrl[3:0] == `JBS_RD_SINGLE && !e.unread)) begin
									launch = 1'b1;
								end
							end
						endcase
					end
					// a prescale whose low four bits are all ones forbids flash operations
					if (launch && e.scale[3:0] == `JBS_SCALE_OFF) begin
						next_e.fail = 1'b1;
					end
					if (launch && e.scale[3:0] != `JBS_SCALE_OFF) begin
						next_e.start = 1'b1;
						next_e.op = lop;
						next_e.fail = 1'b0;
						next_e.st = ENG_WAIT;
					end else begin
						next_e.ack_tgl = ~e.ack_tgl;
					end
				end
			end
			ENG_WAIT: begin
				if (i_flash_done) begin
					next_e.fail = i_flash_fail;
					if (e.op == FOP_READ && !i_flash_fail) begin
						next_e.data = i_flash_rdata;
						next_e.unread = 1'b1;
					end
					if (e.op == FOP_PROG && !i_flash_fail) begin
						next_e.addr = e.addr + 16'h0001;
					end
					next_e.ack_tgl = ~e.ack_tgl;
					next_e.st = ENG_IDLE;
				end
			end
			default: next_e.st = ENG_IDLE;
		endcase
		if (i_srst) begin
			next_e = '0;
			next_e.ctrl = `JBS_CTRL_RST;
			next_e.data = `JBS_DATA_RST;
			next_e.addr = `JBS_ADDR_RST;
			next_e.scale = `JBS_SCALE_RST;
		end
	end

	always_ff @(posedge i_clk) begin
		e <= next_e;
	end

	assign x.ack_tgl = e.ack_tgl;
	assign x.result = e.result;
	assign o_flash_start = e.start;
	assign o_flash_op = e.op;
	assign o_flash_addr = e.addr;
	assign o_flash_wdata = e.data;
	assign o_flash_scale = e.scale;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence done_seq;
		e.st == ENG_WAIT && i_flash_done;
	endsequence
	prog_mode_a: assert property (e.start && e.op == FOP_PROG |-> $past(e.ctrl[7:4]) == `JBS_WR_PROG)
		else $error("program started outside program mode");
	erase_key_a: assert property (e.start && e.op != FOP_READ && e.op != FOP_PROG |-> e.data == `JBS_ERASE_KEY)
		else $error("erase started without key");
	erase_all_a: assert property (e.start && e.op == FOP_ERASE_ALL |-> e.addr[15:1] == `JBS_TOP_USER_PAIR)
		else $error("full erase from wrong address");
	addr_step_a: assert property (done_seq and e.op == FOP_PROG && !i_flash_fail |=> e.addr == $past(e.addr) + 16'h0001)
		else $error("address not advanced after program");
	read_mode_a: assert property (e.start && e.op == FOP_READ |-> $past(e.ctrl[3:0]) inside {`JBS_RD_BLOCK, `JBS_RD_SINGLE})
		else $error("fetch started in store-only read mode");
	busy_end_a: assert property (done_seq |=> e.st == ENG_IDLE && e.ack_tgl != $past(e.ack_tgl))
		else $error("completion not answered");
	reserved_mode_a: assert property (e.start |-> $past(e.ctrl) != `JBS_CTRL_RST || $past(e.ctrl[3:0]) != 4'h0)
		else $error("flash operation with store-only control");
endmodule

/* File: src/jbs_tap_top.sv */
// scan-clock side: tap controller, instruction and data registers, boundary chain
`timescale 1ns/1ps
`include "jbs_cfg.svh"
module jbs_tap_top import jbs_pkg::*; #(
	parameter logic [`JBS_ID_LEN-1:0] IDCODE_VALUE = 32'h0000_1001 // arbitrary value, lsb one as required
) (
	// system clock
	input wire logic i_clk,
	input wire logic i_srst,
	// test access port
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	output logic o_tdo,
	output logic o_tdo_en,
	// boundary cells
	input wire logic [`JBS_BSR_LEN-1:0] i_bnd_capture,
	output logic [`JBS_BSR_LEN-1:0] o_bnd_update,
	output logic o_bnd_drive_en,
	output logic [`JBS_PIN_CNT-1:0] o_core_pin_in,
	// flash macro
	output logic o_flash_start,
	output jbs_fop_type o_flash_op,
	output logic [`JBS_FADDR_W-1:0] o_flash_addr,
	output logic [7:0] o_flash_wdata,
	output logic [7:0] o_flash_scale,
	input wire logic i_flash_done,
	input wire logic i_flash_fail,
	input wire logic [7:0] i_flash_rdata
);
	jbs_xfer_if xf();
	jbs_tck_type t, next_t;
	logic busy;
	logic ind_sel;
	logic bsr_sel;
	jbs_ireg_type ind_reg;
	logic [6:0] dr_len;

	jbs_flash_engine u_engine (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.x(xf.engine),
		.o_flash_start(o_flash_start),
		.o_flash_op(o_flash_op),
		.o_flash_addr(o_flash_addr),
		.o_flash_wdata(o_flash_wdata),
		.o_flash_scale(o_flash_scale),
		.i_flash_done(i_flash_done),
		.i_flash_fail(i_flash_fail),
		.i_flash_rdata(i_flash_rdata)
	);

	always_comb begin
		next_t = t;
		// busy from the moment a command leaves until its answer returns
		busy = t.req_tgl != t.ack_s2;
		ind_sel = 1'b0;
		bsr_sel = 1'b0;
		ind_reg = IREG_CTRL;
		dr_len = 7'd1;
		case (t.ir)
			`JBS_IR_EXTEST, `JBS_IR_SAMPLE: begin
				bsr_sel = 1'b1;
				dr_len = 7'(`JBS_BSR_LEN);
			end
			`JBS_IR_IDCODE: dr_len = 7'(`JBS_ID_LEN);
			`JBS_IR_FCTRL: begin
				ind_sel = 1'b1;
				ind_reg = IREG_CTRL;
				dr_len = 7'(`JBS_IND_LEN);
			end
			`JBS_IR_FDATA: begin
				ind_sel = 1'b1;
				ind_reg = IREG_DATA;
				dr_len = 7'(`JBS_IND_LEN);
			end
			`JBS_IR_FADDR: begin
				ind_sel = 1'b1;
				ind_reg = IREG_ADDR;
				dr_len = 7'(`JBS_IND_LEN);
			end
			`JBS_IR_FSCALE: begin
				ind_sel = 1'b1;
				ind_reg = IREG_SCALE;
				dr_len = 7'(`JBS_IND_LEN);
			end
			default: dr_len = 7'd1; // bypass and unused codes
		endcase
		// crossings into the scan clock
		next_t.rst_s1 = i_srst;
		next_t.rst_s2 = t.rst_s1;
		next_t.cap_s1 = i_bnd_capture;
		next_t.cap_s2 = t.cap_s1;
		next_t.ack_s1 = xf.ack_tgl;
		next_t.ack_s2 = t.ack_s1;
		case (t.tap)
			TAP_TLR: next_t.ir = `JBS_IR_RST;
			TAP_CAP_DR: begin
				if (bsr_sel) begin
					next_t.dr = t.cap_s2;
				end else if (t.ir == `JBS_IR_IDCODE) begin
					next_t.dr = '0;
					next_t.dr[`JBS_ID_LEN-1:0] = IDCODE_VALUE;
				end else if (ind_sel) begin
					next_t.dr = '0;
					next_t.dr[`JBS_IND_LEN-1:0] = {1'b0, xf.result, busy};
					next_t.busy_cap = busy;
				end else begin
					next_t.dr[0] = 1'b0;
				end
			end
			TAP_SHIFT_DR: begin
				// tdi enters at the top of the selected length, so short shifts land high
				for (int i = 0; i < `JBS_BSR_LEN; i++) begin
					if (i == int'(dr_len) - 1) begin
						next_t.dr[i] = i_tdi;
					end else if (i < int'(dr_len) - 1) begin
						next_t.dr[i] = t.dr[i+1];
					end else begin
						next_t.dr[i] = 1'b0;
					end
				end
			end
			TAP_UPD_DR: begin
				if (bsr_sel) begin
					next_t.upd = t.dr;
					next_t.upd[`JBS_CELL_XTAL] = 1'b0;
				end
				// poll (opcode 0x) never updates; commands while busy are dropped
				if (ind_sel && t.dr[`JBS_IND_OP_BIT] && !busy && !t.busy_cap) begin
					next_t.req_tgl = ~t.req_tgl;
					next_t.sel = ind_reg;
					next_t.wr = t.dr[`JBS_IND_RW_BIT];
					next_t.payload = t.dr[`JBS_PAY_W-1:0];
				end
			end
			TAP_CAP_IR: next_t.ir_sh = `JBS_IR_CAPTURE;
			TAP_SHIFT_IR: next_t.ir_sh = {i_tdi, t.ir_sh[`JBS_IR_W-1:1]};
			TAP_UPD_IR: next_t.ir = t.ir_sh;
			default: next_t.ir = t.ir;
		endcase
		case (t.tap)
			TAP_TLR: next_t.tap = i_tms ? TAP_TLR : TAP_RTI;
			TAP_RTI: next_t.tap = i_tms ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_DR: next_t.tap = i_tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: next_t.tap = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: next_t.tap = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: next_t.tap = i_tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: next_t.tap = i_tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: next_t.tap = i_tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: next_t.tap = i_tms ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_IR: next_t.tap = i_tms ? TAP_TLR : TAP_CAP_IR;
			TAP_CAP_IR: next_t.tap = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: next_t.tap = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: next_t.tap = i_tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: next_t.tap = i_tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: next_t.tap = i_tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: next_t.tap = i_tms ? TAP_SEL_DR : TAP_RTI;
			default: next_t.tap = TAP_TLR;
		endcase
		// update cells reach the chip only under external
		next_t.drive_en = t.ir == `JBS_IR_EXTEST;
		for (int k = 0; k < `JBS_PIN_CNT; k++) begin
			next_t.core_in[k] = (t.ir == `JBS_IR_EXTEST) | t.cap_s2[`JBS_PIN_IN_BASE + 2 * k];
		end
		if (t.rst_s2) begin
			next_t = '0;
			next_t.rst_s1 = i_srst;
			next_t.rst_s2 = t.rst_s1;
			next_t.cap_s1 = i_bnd_capture;
			next_t.cap_s2 = t.cap_s1;
			next_t.ack_s1 = xf.ack_tgl;
			next_t.ack_s2 = t.ack_s1;
			next_t.ir = `JBS_IR_RST;
			next_t.tap = TAP_TLR;
		end
		// tdo launched on the rising edge, host samples on the next one
		next_t.tdo = (next_t.tap == TAP_SHIFT_IR) ? next_t.ir_sh[0] : next_t.dr[0];
		next_t.tdo_en = next_t.tap == TAP_SHIFT_IR || next_t.tap == TAP_SHIFT_DR;
	end

	always_ff @(posedge i_tck) begin
		t <= next_t;
	end

	assign xf.req_tgl = t.req_tgl;
	assign xf.sel = t.sel;
	assign xf.wr = t.wr;
	assign xf.payload = t.payload;
	assign o_tdo = t.tdo;
	assign o_tdo_en = t.tdo_en;
	assign o_bnd_update = t.upd;
	assign o_bnd_drive_en = t.drive_en;
	assign o_core_pin_in = t.core_in;

	default clocking @(posedge i_tck); endclocking
	default disable iff (t.rst_s2);
	sequence upd_ind_seq;
		t.tap == TAP_UPD_DR && ind_sel;
	endsequence
	sequence tms_high_seq;
		i_tms [*5];
	endsequence
	tap_reset_a: assert property (tms_high_seq |=> t.tap == TAP_TLR ##1 t.ir == `JBS_IR_RST)
		else $error("five tms ones did not reset the tap");
	ir_load_a: assert property (t.tap == TAP_UPD_IR |=> t.ir == $past(t.ir_sh))
		else $error("instruction not loaded at update");
	bypass_zero_a: assert property (t.tap == TAP_CAP_DR && t.ir == `JBS_IR_BYPASS |=> t.dr[0] == 1'b0)
		else $error("bypass capture not zero");
	idcode_cap_a: assert property (t.tap == TAP_CAP_DR && t.ir == `JBS_IR_IDCODE |=> t.dr[31:0] == IDCODE_VALUE)
		else $error("identification capture wrong");
	ind_format_a: assert property (t.tap == TAP_CAP_DR && ind_sel |=> !t.dr[19] && t.dr[0] == $past(busy))
		else $error("indirect capture format wrong");
	poll_quiet_a: assert property (upd_ind_seq and !t.dr[19] |=> $stable(t.req_tgl))
		else $error("poll issued a command");
	busy_drop_a: assert property (upd_ind_seq and (busy || t.busy_cap) |=> $stable(t.req_tgl))
		else $error("command taken while busy");
	cmd_issue_a: assert property (upd_ind_seq and t.dr[19] && !busy && !t.busy_cap
		|=> t.req_tgl != $past(t.req_tgl) && t.payload == $past(t.dr[17:0]) && t.wr == $past(t.dr[18]))
		else $error("command not issued");
	extest_drive_a: assert property (t.ir == `JBS_IR_EXTEST |=> t.drive_en && t.core_in == '1)
		else $error("external test not forcing inputs");
	sample_quiet_a: assert property (t.ir != `JBS_IR_EXTEST |=> !t.drive_en)
		else $error("update driven outside external test");
	xtal_noupd_a: assert property (t.tap == TAP_UPD_DR && bsr_sel |=> !t.upd[`JBS_CELL_XTAL])
		else $error("oscillator cell updated");
endmodule

/* File: verification/jbs_host_model.sv */
// scan host model: drives the test access port in frames and in single ticks
`timescale 1ns/1ps
module jbs_host_model (
	// test access port
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	input wire logic i_tdo
);
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	// one scan clock; tck rests low between frames
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		o_tms = tms;
		o_tdi = tdi;
		#32;
		tdo = i_tdo;
		o_tck = 1'b1;
		#32;
		o_tck = 1'b0;
	endtask
	// five or more ones reach test-logic-reset, then park in idle
	task automatic reset_frame();
		logic d;
		for (int i = 0; i < 6; i++) begin
			tick(1'b1, 1'b0, d);
		end
		tick(1'b0, 1'b0, d);
	endtask
	// n bits lsb first from idle and back; short shifts leave the last bit on top
	task automatic scan(input logic sel_ir, input int n, input logic [127:0] din, output logic [127:0] dout);
		logic d;
		dout = '0;
		tick(1'b1, 1'b0, d);
		if (sel_ir) begin
			tick(1'b1, 1'b0, d);
		end
		tick(1'b0, 1'b0, d);
		tick(1'b0, 1'b0, d);
		for (int i = 0; i < n; i++) begin
			tick(logic'(i == n - 1), din[i], d);
			dout[i] = d;
		end
		tick(1'b1, 1'b0, d);
		tick(1'b0, 1'b0, d);
		// released data line must not look like the last bit
		o_tdi = ~o_tdi;
	endtask
endmodule

/* File: verification/jbs_tap_top_test.sv */
// self-checking bench for the scan port and flash access block
`timescale 1ns/1ps
module jbs_tap_top_test import jbs_pkg::*; ;
	localparam logic [31:0] ID = 32'h0000_1001; // arbitrary value
	localparam logic [86:0] PAT = {23'h5A_3C96, 32'hC33C_A55A, 32'h0F1E_2D4F};
	logic i_clk, i_srst, tck, tms, tdi, tdo, tdo_en, drive_en, fl_start, fl_done, fl_fail;
	logic [86:0] bnd_cap, bnd_upd;
	logic [31:0] core_in;
	jbs_fop_type fl_op, last_op;
	logic [15:0] fl_addr, last_addr;
	logic [7:0] fl_wdata, fl_scale, fl_rdata, last_wdata;
	int err_total = 0;
	int checks_done = 0;
	int starts = 0;
	// read data only meaningful alongside done
	assign fl_rdata = fl_done ? 8'h3C : 8'hC3;
	jbs_host_model host_u (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
	jbs_tap_top #(.IDCODE_VALUE(ID)) dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_tck(tck), .i_tms(tms),
		.i_tdi(tdi), .o_tdo(tdo), .o_tdo_en(tdo_en), .i_bnd_capture(bnd_cap), .o_bnd_update(bnd_upd),
		.o_bnd_drive_en(drive_en), .o_core_pin_in(core_in), .o_flash_start(fl_start), .o_flash_op(fl_op),
		.o_flash_addr(fl_addr), .o_flash_wdata(fl_wdata), .o_flash_scale(fl_scale),
		.i_flash_done(fl_done), .i_flash_fail(fl_fail), .i_flash_rdata(fl_rdata));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// flash macro: slow enough that busy is always seen high
	initial begin
		fl_done = 1'b0;
		forever begin
			@(posedge i_clk);
			// look after the launching edge has settled
			#1;
			if (fl_start === 1'b1) begin
				starts++;
				last_op = fl_op;
				last_addr = fl_addr;
				last_wdata = fl_wdata;
				repeat (10) @(posedge i_clk);
				#1 fl_done = 1'b1;
				@(posedge i_clk);
				#1 fl_done = 1'b0;
			end
		end
	end
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic ir_load(input logic [15:0] code);
		logic [127:0] d;
		host_u.scan(1'b1, 16, {112'h0, code}, d);
		check("ir capture", d[15:0], 16'h0001);
	endtask
	task automatic dr(input int n, input logic [127:0] din, output logic [127:0] dout);
		host_u.scan(1'b0, n, din, dout);
	endtask
	// one-bit polls until busy reads low
	task automatic wait_idle(output int polls);
		logic [127:0] d;
		polls = 0;
		do begin
			dr(1, '0, d);
			polls++;
		end while (d[0] !== 1'b0 && polls < 60);
		if (d[0] !== 1'b0) begin
			err_total++;
			test_done();
		end
	endtask
	task automatic ind_write(input logic [15:0] code, input int w, input logic [17:0] val, output int polls);
		logic [127:0] d;
		ir_load(code);
		dr(w + 2, (128'h3 << w) | 128'(val), d);
		wait_idle(polls);
	endtask
	// ir stays put until busy is low again
	task automatic ind_read(input logic [15:0] code, input int w, output logic [127:0] res);
		logic [127:0] d;
		int polls;
		ir_load(code);
		dr(2, 128'h2, d);
		wait_idle(polls);
		dr(w + 1, '0, d);
		check("read busy", d[0], 1'b0);
		res = (d >> 1) & ((128'h1 << w) - 1);
	endtask
	task automatic s_id();
		logic [127:0] d;
		dr(32, '0, d);
		check("idcode", d[31:0], ID);
	endtask
	task automatic s_bypass();
		logic [127:0] d;
		ir_load(16'hFFFF);
		dr(4, 128'hB, d);
		check("bypass", d[3:0], 4'h6);
		check("tdo parked", tdo_en, 1'b0);
	endtask
	task automatic s_sample();
		logic [127:0] d;
		logic [31:0] pins;
		@(posedge i_clk);
		#1 bnd_cap = PAT;
		ir_load(16'h0002);
		dr(87, ~128'(PAT), d);
		check("sample capture", d[86:0], PAT);
		check("sample drive", drive_en, 1'b0);
		for (int k = 0; k < 32; k++) begin
			pins[k] = PAT[24 + 2 * k];
		end
		check("pins to core", core_in, pins);
	endtask
	task automatic s_extest();
		logic [127:0] d;
		logic [86:0] exp;
		logic q;
		ir_load(16'h0000);
		// drive enable and forced inputs follow the loaded instruction one scan clock later
		host_u.tick(1'b0, 1'b0, q);
		check("extest drive", drive_en, 1'b1);
		check("extest core", core_in, 32'hFFFF_FFFF);
		dr(87, 128'(PAT), d);
		check("extest capture", d[86:0], PAT);
		exp = PAT;
		exp[2] = 1'b0;
		check("extest update", bnd_upd, exp);
		ir_load(16'h0004);
	endtask
	task automatic s_program();
		int p;
		int s0;
		logic [127:0] r;
		ind_write(16'h0082, 8, 18'h10, p);
		ind_write(16'h0084, 16, 18'h1234, p);
		s0 = starts;
		ind_write(16'h0083, 8, 18'h5A, p);
		check("busy seen", p > 1, 1'b1);
		check("prog start", starts - s0, 1);
		check("prog op", last_op, FOP_PROG);
		check("prog addr", last_addr, 16'h1234);
		check("prog byte", last_wdata, 8'h5A);
		ind_read(16'h0084, 19, r);
		check("addr inc", r, 128'h1235);
	endtask
	task automatic s_erase();
		int p;
		int s0;
		logic [127:0] r;
		ind_write(16'h0082, 8, 18'h20, p);
		ind_write(16'h0084, 16, 18'h7DFE, p);
		s0 = starts;
		ind_write(16'h0083, 8, 18'h00, p);
		check("no key", starts - s0, 0);
		ind_write(16'h0083, 8, 18'hA5, p);
		check("erase all", starts - s0, 1);
		check("erase all op", last_op, FOP_ERASE_ALL);
		ind_read(16'h0084, 19, r);
		check("addr kept", r, 128'h7DFE);
		ind_write(16'h0084, 16, 18'h0200, p);
		ind_write(16'h0083, 8, 18'hA5, p);
		check("page op", last_op, FOP_ERASE_PAGE);
		check("page addr", last_addr, 16'h0200);
		ind_write(16'h0082, 8, 18'h30, p);
		s0 = starts;
		ind_write(16'h0083, 8, 18'hA5, p);
		check("reserved mode", starts - s0, 0);
	endtask
	task automatic s_read();
		int p;
		int s0;
		logic [127:0] r;
		ind_write(16'h0082, 8, 18'h01, p);
		ind_write(16'h0084, 16, 18'h0010, p);
		s0 = starts;
		ind_read(16'h0083, 10, r);
		check("held byte", r, {8'hA5, 2'b00});
		check("fetch start", starts - s0, 1);
		check("fetch op", last_op, FOP_READ);
		check("fetch addr", last_addr, 16'h0010);
		ind_read(16'h0083, 10, r);
		check("fetched byte", r, {8'h3C, 2'b00});
		ind_write(16'h0082, 8, 18'h00, p);
		s0 = starts;
		ind_read(16'h0083, 10, r);
		check("store only read", starts - s0, 0);
	endtask
	task automatic s_scale();
		int p;
		int s0;
		logic [127:0] r;
		ind_write(16'h0082, 8, 18'h10, p);
		ind_write(16'h0085, 8, 18'hFF, p);
		check("scale out", fl_scale, 8'hCF);
		ind_read(16'h0085, 8, r);
		check("scale read", r, 128'hCF);
		s0 = starts;
		ind_write(16'h0083, 8, 18'h11, p);
		check("scale refuse", starts - s0, 0);
		ind_write(16'h0082, 8, 18'h00, p);
		ind_read(16'h0083, 10, r);
		check("fail flag", r, {8'h11, 2'b10});
		ind_write(16'h0085, 8, 18'h00, p);
		check("scale clear", fl_scale, 8'h00);
	endtask
	initial begin
		i_srst = 1'b1;
		bnd_cap = '0;
		fl_fail = 1'b0;
		fork
			begin
				repeat (8) @(posedge i_clk);
				#1 i_srst = 1'b0;
			end
			host_u.reset_frame();
		join
		s_id();
		s_bypass();
		s_sample();
		s_extest();
		s_program();
		s_erase();
		s_read();
		s_scale();
		test_done();
	end
endmodule
